// file: rtl/usbd_pkg.sv
package usbd_pkg;
	// descriptor count and index width
	localparam int NUM_DESC = 4;
	localparam int IDX_W    = 2;
	// per-descriptor word offsets, stride 16 bytes
	localparam logic [11:0] OFS_STAT  = 12'h000;
	localparam logic [11:0] OFS_CNT   = 12'h004;
	localparam logic [11:0] OFS_EPCTL = 12'h008;
	localparam int          STRIDE_SH = 4;
	localparam logic [11:0] OFS_ENG   = 12'h100;
	// status byte fields
	localparam int OWN_BIT      = 7;
	localparam int TOGGLE_BIT   = 6;
	localparam int TOGCHK_BIT   = 3;
	localparam int BUFSTALL_BIT = 2;
	localparam int PID_LSB      = 2;
	localparam int PID_MSB      = 5;
	localparam logic [7:0] STAT_WR_MASK = 8'hCF;
	localparam logic [7:0] STAT_RST     = 8'h00;
	// endpoint control fields
	localparam int EP_STALL_BIT = 0;
	localparam int EP_EN_BIT    = 1;
	localparam logic [1:0] EP_RST = 2'h0;
	// token identifiers
	localparam logic [3:0] PID_OUT   = 4'h1;
	localparam logic [3:0] PID_IN    = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	// answer codes to the engine
	localparam logic [1:0] ANS_ACCEPT = 2'h0;
	localparam logic [1:0] ANS_NAK    = 2'h1;
	localparam logic [1:0] ANS_STALL  = 2'h2;
	localparam logic [1:0] ANS_IGNORE = 2'h3;
	// token kind recorded on write-back
	function automatic logic pid_recorded(input logic [3:0] p);
		pid_recorded = (p == PID_OUT) || (p == PID_IN) || (p == PID_SETUP);
	endfunction
endpackage

// file: rtl/usbd_apb_decode.sv
`timescale 1ns/1ps
// splits an apb address into descriptor index and word
module usbd_apb_decode
(
	input  wire logic [11:0]                paddr,
	output logic      [usbd_pkg::IDX_W-1:0] idx,
	output logic                            hit_stat,
	output logic                            hit_cnt,
	output logic                            hit_ep,
	output logic                            hit_eng
);
	import usbd_pkg::*;

	// word offset within a descriptor window
	function automatic logic word_is(input logic [11:0] a, input logic [11:0] w);
		word_is = (a[STRIDE_SH-1:0] == w[STRIDE_SH-1:0]);
	endfunction

	logic in_desc; // address lies in the descriptor area

	// decode
	always_comb begin
		in_desc  = (paddr >> STRIDE_SH) < 12'(NUM_DESC);
		idx      = paddr[STRIDE_SH+IDX_W-1:STRIDE_SH];
		hit_stat = in_desc && word_is(paddr, OFS_STAT);
		hit_cnt  = in_desc && word_is(paddr, OFS_CNT);
		hit_ep   = in_desc && word_is(paddr, OFS_EPCTL);
		hit_eng  = (paddr == OFS_ENG);
	end
endmodule

// file: rtl/usbd_token_judge.sv
`timescale 1ns/1ps
// decides the answer to one token against one descriptor
module usbd_token_judge
(
	input  wire logic [7:0] stat,
	input  wire logic [1:0] ep_ctl,
	input  wire logic [3:0] pid,
	input  wire logic       pkt_data1,
	output logic      [1:0] code
);
	import usbd_pkg::*;

	logic mismatch; // received toggle differs from expected

	// priority: ownership, buffer stall, endpoint, toggle
	always_comb begin
		mismatch = stat[TOGCHK_BIT] && (pkt_data1 != stat[TOGGLE_BIT]);
		if (!stat[OWN_BIT]) begin
			code = ANS_NAK;
		end else if (stat[BUFSTALL_BIT]) begin
			code = ANS_STALL;
		end else if (!ep_ctl[EP_EN_BIT]) begin
			code = ANS_IGNORE;
		end else if (ep_ctl[EP_STALL_BIT]) begin
			code = ANS_STALL;
		end else if (pid == PID_OUT && mismatch) begin
			code = ANS_IGNORE;
		end else begin
			code = ANS_ACCEPT;
		end
	end
endmodule

// file: rtl/usbd_desc_status.sv
`timescale 1ns/1ps
module usbd_desc_status
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [11:0]                paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       tok_valid,
	input  wire logic [3:0]                 tok_pid,
	input  wire logic [usbd_pkg::IDX_W-1:0] tok_desc,
	input  wire logic                       pkt_data1,
	input  wire logic                       done_valid,
	input  wire logic [usbd_pkg::IDX_W-1:0] done_desc,
	input  wire logic [3:0]                 done_pid,
	input  wire logic [9:0]                 done_count,
	output logic                            ans_valid,
	output logic      [1:0]                 ans_code,
	output logic                            ans_data1,
	output logic      [9:0]                 ans_count
);
	import usbd_pkg::*;

	// descriptor storage
	logic [7:0]       stat        [NUM_DESC];
	logic [7:0]       next_stat   [NUM_DESC];
	logic [7:0]       cnt_lo      [NUM_DESC];
	logic [7:0]       next_cnt_lo [NUM_DESC];
	logic [1:0]       ep_ctl      [NUM_DESC];
	// apb decode results
	logic [IDX_W-1:0] a_idx;
	logic             hit_stat;
	logic             hit_cnt;
	logic             hit_ep;
	logic             hit_eng;
	logic             wr_acc;
	logic             setup_ph;
	logic [31:0]      next_prdata;
	logic             next_pslverr;
	// token path
	logic [7:0]       tok_stat;
	logic [1:0]       judge_code;
	logic             next_ans_valid;
	logic [1:0]       next_ans_code;
	logic             next_ans_data1;
	logic [9:0]       next_ans_count;
	// last answer seen by software
	logic [1:0]       last_code;
	logic [1:0]       next_last_code;
	logic             done_ok;

	// zero-wait slave, always ready
	assign pready   = 1'b1;
	assign setup_ph = psel && !penable;
	assign wr_acc   = psel && penable && pwrite;
	assign tok_stat = stat[tok_desc];
	assign done_ok  = done_valid && stat[done_desc][OWN_BIT];

	// address decode
	usbd_apb_decode u_dec (
		.paddr    (paddr),
		.idx      (a_idx),
		.hit_stat (hit_stat),
		.hit_cnt  (hit_cnt),
		.hit_ep   (hit_ep),
		.hit_eng  (hit_eng)
	);

	// answer for the presented token
	usbd_token_judge u_judge (
		.stat      (tok_stat),
		.ep_ctl    (ep_ctl[tok_desc]),
		.pid       (tok_pid),
		.pkt_data1 (pkt_data1),
		.code      (judge_code)
	);

	// endpoint control registers, one per descriptor
	genvar g;
	generate
		for (g = 0; g < NUM_DESC; g++) begin : g_ep
			logic [1:0] next_ep;
			// software write only
			always_comb begin
				next_ep = ep_ctl[g];
				if (wr_acc && hit_ep && a_idx == IDX_W'(g)) begin
					next_ep = pwdata[1:0];
				end
			end
			// register
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ep_ctl[g] <= EP_RST;
				end else begin
					ep_ctl[g] <= next_ep;
				end
			end
		end
	endgenerate

	// descriptor next values: engine write-back, then software
	always_comb begin
		for (int i = 0; i < NUM_DESC; i++) begin
			next_stat[i]   = stat[i];
			next_cnt_lo[i] = cnt_lo[i];
		end
		// engine completion hands descriptor back
		if (done_ok) begin
			next_stat[done_desc][OWN_BIT] = 1'b0;
			next_stat[done_desc][1:0]     = done_count[9:8];
			next_cnt_lo[done_desc]        = done_count[7:0];
			// only token kinds are recorded
			if (pid_recorded(done_pid)) begin
				next_stat[done_desc][PID_MSB:PID_LSB] = done_pid;
			end
		end
		// software status write; reserved bits forced low
		if (wr_acc && hit_stat) begin
			next_stat[a_idx] = pwdata[7:0] & STAT_WR_MASK;
		end
		// count byte locked while engine owns it
		if (wr_acc && hit_cnt && !stat[a_idx][OWN_BIT]) begin
			next_cnt_lo[a_idx] = pwdata[7:0];
		end
	end

	// descriptor registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_DESC; i++) begin
				stat[i]   <= STAT_RST;
				cnt_lo[i] <= STAT_RST;
			end
		end else begin
			for (int i = 0; i < NUM_DESC; i++) begin
				stat[i]   <= next_stat[i];
				cnt_lo[i] <= next_cnt_lo[i];
			end
		end
	end

	// read data captured in setup phase
	always_comb begin
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (setup_ph) begin
			next_prdata = 32'h0000_0000;
			if (hit_stat) begin
				next_prdata[7:0] = stat[a_idx];
			end else if (hit_cnt) begin
				next_prdata[7:0] = cnt_lo[a_idx];
			end else if (hit_ep) begin
				next_prdata[1:0] = ep_ctl[a_idx];
			end else if (hit_eng) begin
				next_prdata[1:0] = last_code;
			end else begin
				next_pslverr = 1'b1;
			end
		end else if (psel) begin
			next_pslverr = pslverr;
		end
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// token answer next values
	always_comb begin
		next_ans_valid = tok_valid;
		next_ans_code  = ans_code;
		next_ans_data1 = ans_data1;
		next_ans_count = ans_count;
		next_last_code = last_code;
		if (tok_valid) begin
			next_ans_code  = judge_code;
			next_ans_data1 = tok_stat[TOGGLE_BIT];
			next_ans_count = {tok_stat[1:0], cnt_lo[tok_desc]};
			next_last_code = judge_code;
		end
	end

	// token answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ans_valid <= 1'b0;
			ans_code  <= ANS_NAK;
			ans_data1 <= 1'b0;
			ans_count <= 10'h000;
			last_code <= ANS_NAK;
		end else begin
			ans_valid <= next_ans_valid;
			ans_code  <= next_ans_code;
			ans_data1 <= next_ans_data1;
			ans_count <= next_ans_count;
			last_code <= next_last_code;
		end
	end

	// disabled endpoint never stalls by request
	AST_EP_STALL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid && tok_stat[OWN_BIT] && !tok_stat[BUFSTALL_BIT] && !ep_ctl[tok_desc][EP_EN_BIT]
		|=> ans_valid && ans_code == ANS_IGNORE)
		else $error("stall request acted on while endpoint disabled");

	// enabled endpoint with a stall request stalls
	AST_EP_STALL_ON: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid && tok_stat[OWN_BIT] && !tok_stat[BUFSTALL_BIT] && ep_ctl[tok_desc][EP_EN_BIT]
		&& ep_ctl[tok_desc][EP_STALL_BIT] |=> ans_valid && ans_code == ANS_STALL)
		else $error("stall request ignored on enabled endpoint");

	// engine never uses a core-owned descriptor
	AST_NOT_OWNED: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid && !tok_stat[OWN_BIT] |=> ans_valid && ans_code == ANS_NAK)
		else $error("token served on core-owned descriptor");

	// count byte held while the engine owns the descriptor
	AST_CNT_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && hit_cnt && stat[a_idx][OWN_BIT] && !(done_ok && done_desc == a_idx)
		|=> cnt_lo[$past(a_idx)] == $past(cnt_lo[a_idx]))
		else $error("count byte changed by core while engine owns it");

	// write-back on a core-owned descriptor is dropped
	AST_DONE_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		done_valid && !stat[done_desc][OWN_BIT] && !wr_acc
		|=> stat[$past(done_desc)] == $past(stat[done_desc]))
		else $error("write-back applied to core-owned descriptor");

	// toggle bit picks the data packet
	AST_TOGGLE_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid |=> ans_data1 == $past(tok_stat[TOGGLE_BIT]))
		else $error("data packet kind differs from toggle bit");

	// check off means toggle ignored
	AST_CHECK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid && tok_stat[OWN_BIT] && !tok_stat[BUFSTALL_BIT] && !tok_stat[TOGCHK_BIT]
		&& ep_ctl[tok_desc] == 2'h2 |=> ans_code == ANS_ACCEPT)
		else $error("toggle disregarded check failed");

	// reserved status bits always stored low from the bus
	AST_RSVD_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && hit_stat |=> (stat[$past(a_idx)] & ~STAT_WR_MASK) == 8'h00)
		else $error("reserved status bits stored high");

	// ten-bit count assembled from both bytes
	AST_COUNT10: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid |=> ans_count == {$past(tok_stat[1:0]), $past(cnt_lo[tok_desc])})
		else $error("byte count assembly wrong");

	// completion stores actual count and frees descriptor
	AST_WRITEBACK: assert property (@(posedge pclk) disable iff (!presetn)
		done_ok && !(wr_acc && (hit_stat || hit_cnt) && a_idx == done_desc)
		|=> {stat[$past(done_desc)][1:0], cnt_lo[$past(done_desc)]} == $past(done_count)
		&& !stat[$past(done_desc)][OWN_BIT])
		else $error("write-back count or owner wrong");

	// token id recorded for token kinds
	AST_PID_REC: assert property (@(posedge pclk) disable iff (!presetn)
		done_ok && pid_recorded(done_pid) && !(wr_acc && hit_stat && a_idx == done_desc)
		|=> stat[$past(done_desc)][PID_MSB:PID_LSB] == $past(done_pid))
		else $error("token id not recorded");

	// other token kinds leave the id field alone
	AST_PID_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		done_ok && !pid_recorded(done_pid) && !(wr_acc && hit_stat && a_idx == done_desc)
		|=> stat[$past(done_desc)][PID_MSB:PID_LSB] == $past(stat[done_desc][PID_MSB:PID_LSB]))
		else $error("id field changed by a non-token write-back");

	// write-back never touches bit six
	AST_WB_BIT6: assert property (@(posedge pclk) disable iff (!presetn)
		done_ok && !(wr_acc && hit_stat && a_idx == done_desc)
		|=> stat[$past(done_desc)][TOGGLE_BIT] == $past(stat[done_desc][TOGGLE_BIT]))
		else $error("write-back changed bit six");

	// mismatched OUT ignored, SETUP accepted
	AST_MISMATCH: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid && tok_stat[OWN_BIT] && !tok_stat[BUFSTALL_BIT] && ep_ctl[tok_desc] == 2'h2
		&& tok_stat[TOGCHK_BIT] && pkt_data1 != tok_stat[TOGGLE_BIT]
		|=> ans_code == ((($past(tok_pid)) == PID_SETUP) ? ANS_ACCEPT :
		(($past(tok_pid)) == PID_OUT) ? ANS_IGNORE : ANS_ACCEPT))
		else $error("toggle mismatch handling wrong");

	// buffer stall answers stall and keeps the descriptor
	AST_BUF_STALL: assert property (@(posedge pclk) disable iff (!presetn)
		tok_valid && tok_stat[OWN_BIT] && tok_stat[BUFSTALL_BIT] && !done_valid && !wr_acc
		|=> ans_code == ANS_STALL && stat[$past(tok_desc)] == $past(tok_stat))
		else $error("buffer stall did not stall or changed descriptor");
endmodule

// file: testbench/usbd_eng_model.sv
`timescale 1ns/1ps
// stand-in for the serial engine: issues tokens and write-backs
module usbd_eng_model
	import usbd_pkg::*;
(
	input  wire logic             pclk,
	output logic                  tok_valid,
	output logic      [3:0]       tok_pid,
	output logic      [IDX_W-1:0] tok_desc,
	output logic                  pkt_data1,
	output logic                  done_valid,
	output logic      [IDX_W-1:0] done_desc,
	output logic      [3:0]       done_pid,
	output logic      [9:0]       done_count,
	input  wire logic             ans_valid,
	input  wire logic [1:0]       ans_code,
	input  wire logic             ans_data1,
	input  wire logic [9:0]       ans_count
);
	// quiet lines at time zero
	initial begin
		{tok_valid, tok_pid, tok_desc, pkt_data1} = '0;
		{done_valid, done_desc, done_pid, done_count} = '0;
	end
	// one token pulse, then wait for the answer pulse
	task automatic token(input logic [3:0] p, input logic [IDX_W-1:0] d, input logic t,
			output logic [1:0] c, output logic t1, output logic [9:0] n);
		@(posedge pclk);
		tok_valid <= 1'b1;
		tok_pid   <= p;
		tok_desc  <= d;
		pkt_data1 <= t;
		@(posedge pclk);
		tok_valid <= 1'b0;
		// released lines carry junk, not the last value
		tok_pid   <= ~p;
		tok_desc  <= ~d;
		pkt_data1 <= ~t;
		do @(posedge pclk); while (ans_valid !== 1'b1);
		c  = ans_code;
		t1 = ans_data1;
		n  = ans_count;
	endtask
	// one completed transfer written back
	task automatic done(input logic [IDX_W-1:0] d, input logic [3:0] p, input logic [9:0] n);
		@(posedge pclk);
		done_valid <= 1'b1;
		done_desc  <= d;
		done_pid   <= p;
		done_count <= n;
		@(posedge pclk);
		done_valid <= 1'b0;
		done_desc  <= ~d;
		done_pid   <= ~p;
		done_count <= ~n;
	endtask
endmodule

// file: testbench/usbd_desc_status_tb.sv
`timescale 1ns/1ps
module usbd_desc_status_tb;
	import usbd_pkg::*;
	// one table row: setup, token and expected answer
	typedef struct packed {
		logic [7:0] st;
		logic [7:0] cl;
		logic [1:0] ep;
		logic [3:0] pid;
		logic       d1;
		logic [1:0] code;
	} usbd_row_s;
	logic             pclk    = 1'b0;
	logic             presetn = 1'b0;
	logic [11:0]      paddr   = '0;
	logic             psel    = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite  = 1'b0;
	logic [31:0]      pwdata  = '0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             tok_valid, pkt_data1, done_valid, ans_valid, ans_data1;
	logic [3:0]       tok_pid, done_pid;
	logic [IDX_W-1:0] tok_desc, done_desc;
	logic [9:0]       done_count, ans_count;
	logic [1:0]       ans_code;
	int               n_errors    = 0;
	int               checks_done = 0;
	usbd_row_s        rows [10] = '{
		'{8'h00, 8'h00, 2'h2, PID_OUT,   1'b0, ANS_NAK},    // core owns
		'{8'h84, 8'h00, 2'h2, PID_IN,    1'b0, ANS_STALL},  // buffer stall
		'{8'h80, 8'h00, 2'h1, PID_IN,    1'b0, ANS_IGNORE}, // stall on disabled ep
		'{8'h80, 8'h00, 2'h3, PID_IN,    1'b0, ANS_STALL},  // stall on enabled ep
		'{8'h88, 8'h00, 2'h2, PID_OUT,   1'b1, ANS_IGNORE}, // toggle mismatch
		'{8'hC8, 8'h00, 2'h2, PID_OUT,   1'b1, ANS_ACCEPT}, // toggle match
		'{8'h80, 8'h00, 2'h2, PID_OUT,   1'b1, ANS_ACCEPT}, // check off
		'{8'h88, 8'h00, 2'h2, PID_SETUP, 1'b1, ANS_ACCEPT}, // setup passes
		'{8'h83, 8'hFF, 2'h2, PID_IN,    1'b0, ANS_ACCEPT}, // full count
		'{8'hC0, 8'h10, 2'h2, PID_OUT,   1'b0, ANS_ACCEPT}};
	logic [31:0]      r;
	logic             e, t1;
	logic [1:0]       c;
	logic [9:0]       n;
	logic [11:0]      b;

	always #12.5 pclk = ~pclk;

	usbd_desc_status u_usbd_desc_status (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_desc(tok_desc),
		.pkt_data1(pkt_data1), .done_valid(done_valid), .done_desc(done_desc), .done_pid(done_pid),
		.done_count(done_count), .ans_valid(ans_valid), .ans_code(ans_code), .ans_data1(ans_data1),
		.ans_count(ans_count));
	usbd_eng_model u_usbd_eng_model (.pclk(pclk), .tok_valid(tok_valid), .tok_pid(tok_pid),
		.tok_desc(tok_desc), .pkt_data1(pkt_data1), .done_valid(done_valid), .done_desc(done_desc),
		.done_pid(done_pid), .done_count(done_count), .ans_valid(ans_valid), .ans_code(ans_code),
		.ans_data1(ans_data1), .ans_count(ans_count));

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
			n_errors++;
		end
	endtask
	// verdict and end of run
	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard, far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		$display("CHECK FAILED at %0t: timeout", $time);
		n_errors++;
		results();
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped place
		apb(1'b0, OFS_STAT, '0);
		chk(r, 32'h0000_0000, "status reset value");
		apb(1'b0, 12'h0FC, '0);
		chk({e, r[30:0]}, 32'h8000_0000, "unmapped read error");
		// table of token decisions
		foreach (rows[i]) begin
			b = 12'(i % NUM_DESC) << STRIDE_SH;
			apb(1'b1, b | OFS_STAT, 32'h0);
			apb(1'b1, b | OFS_CNT, {24'h0, rows[i].cl});
			apb(1'b1, b | OFS_EPCTL, {30'h0, rows[i].ep});
			apb(1'b1, b | OFS_STAT, {24'h0, rows[i].st});
			apb(1'b0, b | OFS_EPCTL, '0);
			chk(r, {30'h0, rows[i].ep}, "endpoint control readback");
			u_usbd_eng_model.token(rows[i].pid, IDX_W'(i % NUM_DESC), rows[i].d1, c, t1, n);
			chk(32'(c), 32'(rows[i].code), "answer code");
			if (rows[i].st[OWN_BIT]) begin
				chk({31'h0, t1}, {31'h0, rows[i].st[TOGGLE_BIT]}, "data packet kind");
				chk(32'(n), {22'h0, rows[i].st[1:0], rows[i].cl}, "byte count");
			end
			apb(1'b0, b | OFS_STAT, '0);
			chk(r, {24'h0, rows[i].st}, "status kept after token");
			apb(1'b0, OFS_ENG, '0);
			chk(r, 32'(rows[i].code), "last answer readback");
		end
		// bits five and four never stored
		apb(1'b1, OFS_STAT, 32'hF3);
		apb(1'b0, OFS_STAT, '0);
		chk(r, 32'hC3, "reserved bits stored low");
		// count low locked while engine owns it
		b = 12'h030;
		apb(1'b1, b | OFS_STAT, 32'hC8);
		apb(1'b1, b | OFS_CNT, 32'h77);
		apb(1'b0, b | OFS_CNT, '0);
		chk(r, 32'h00, "count locked while engine owns");
		// write-back: owner back to core, pid and count stored
		u_usbd_eng_model.done(2'd3, PID_OUT, 10'h2A5);
		apb(1'b0, b | OFS_STAT, '0);
		chk(r, 32'h46, "write-back status");
		apb(1'b0, b | OFS_CNT, '0);
		chk(r, 32'hA5, "write-back count low");
		// write-back on a core-owned descriptor is dropped
		u_usbd_eng_model.done(2'd3, PID_IN, 10'h001);
		apb(1'b0, b | OFS_STAT, '0);
		chk(r, 32'h46, "write-back dropped when core owns");
		// other token kinds leave bits five to two alone
		apb(1'b1, b | OFS_STAT, 32'h88);
		u_usbd_eng_model.done(2'd3, 4'h5, 10'h100);
		apb(1'b0, b | OFS_STAT, '0);
		chk(r, 32'h09, "non-token write-back keeps id field");
		// reset in mid-run clears descriptors and the answer count, and sets the answer code to NAK
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({30'h0, ans_code}, {30'h0, ANS_NAK}, "answer code after reset");
		chk({22'h0, ans_count}, 32'h0, "answer count after reset");
		apb(1'b0, b | OFS_STAT, '0);
		chk(r, 32'h0, "status after reset");
		apb(1'b0, b | OFS_EPCTL, '0);
		chk(r, 32'h0, "endpoint control after reset");
		apb(1'b0, OFS_ENG, '0);
		chk(r, 32'(ANS_NAK), "last answer after reset");
		results();
	end
endmodule
